// >>> hw/pde_pkg.sv
// Package for the eight-pin port: register map, field layouts, drive codes, carriers.
// Assumes a 32-bit AXI4-Lite register bus and one 125 MHz clock.
`default_nettype none
package pde_pkg;
   localparam int unsigned NPIN   = 8;
   localparam int unsigned NAUX   = 16;
   localparam int unsigned AW     = 8;

   // Port form registers (byte addresses)
   localparam logic [7:0] A_OUT   = 8'h00;   // port_output_value
   localparam logic [7:0] A_PV    = 8'h04;   // pin_state_readback
   localparam logic [7:0] A_DM0   = 8'h08;   // drive mode bit 0, per pin
   localparam logic [7:0] A_DM1   = 8'h0c;
   localparam logic [7:0] A_DM2   = 8'h10;
   localparam logic [7:0] A_SLW   = 8'h14;   // slow_slew_select
   localparam logic [7:0] A_IBD   = 8'h18;   // input buffer disable
   localparam logic [7:0] A_BIE   = 8'h1c;   // bidirectional enable
   localparam logic [7:0] A_IT0   = 8'h20;   // edge type bit 0
   localparam logic [7:0] A_IT1   = 8'h24;   // edge type bit 1
   localparam logic [7:0] A_IST   = 8'h28;   // edge status, clear on read
   localparam logic [7:0] A_CFG   = 8'h2c;   // port config
   localparam logic [7:0] A_SPC   = 8'h30;   // special pin config
   localparam logic [7:0] A_AUXS  = 8'h34;   // aux output-enable select, 4 bits per pin
   localparam logic [7:0] A_AUXS1 = 8'h38;
   localparam logic [7:0] A_PIN0  = 8'h40;   // per-pin form, 8 words
   localparam logic [7:0] A_PIN7  = 8'h5c;

   // Per-pin form layout
   localparam int unsigned PF_OUT = 0;
   localparam int unsigned PF_PV  = 1;
   localparam int unsigned PF_DM  = 2;  // 3 bits
   localparam int unsigned PF_SLW = 5;
   localparam int unsigned PF_BIE = 6;
   localparam int unsigned PF_IBD = 7;

   // Port config layout
   localparam int unsigned CF_LVTTL = 0;

   // Special pin config: per pin pair (4 pairs) and per pin
   localparam int unsigned SC_REG  = 0;  // 8 bits: regulated output level per pin
   localparam int unsigned SC_REF  = 8;  // 4 pairs x 2 bits threshold select
   localparam int unsigned SC_CMP  = 16; // 4 bits comparator per pair
   localparam int unsigned SC_HYST = 20; // 8 bits hysteresis per pin

   localparam logic [1:0] RESP_OK  = 2'b00;
   localparam logic [1:0] RESP_ERR = 2'b10;

   typedef enum logic [2:0] {
      DM_ANA_OFF = 3'h0, DM_DIG_INP = 3'h1, DM_PULL_UP = 3'h2, DM_PULL_DN = 3'h3,
      DM_OD_LOW  = 3'h4, DM_OD_HIGH = 3'h5, DM_STRONG  = 3'h6, DM_PULL_UD = 3'h7
   } pde_drive_mode_code_t;

   typedef enum logic [1:0] {
      IT_NONE = 2'h0, IT_RISE = 2'h1, IT_FALL = 2'h2, IT_BOTH = 2'h3
   } pde_edge_t;

   typedef enum logic [1:0] {
      TH_HALF_BANK = 2'h0, TH_04_BANK = 2'h1, TH_HALF_REF = 2'h2, TH_FULL_REF = 2'h3
   } pde_thresh_t;

   // One pin's pad controls
   typedef struct packed {
      logic strong_hi;
      logic strong_lo;
      logic res_hi;
      logic res_lo;
      logic in_en;
      logic slow;
      logic reg_lvl;
   } pde_pad_t;

   typedef struct packed {
      logic [AW-1:0] awaddr;
      logic          awvalid;
      logic [31:0]   wdata;
      logic [3:0]    wstrb;
      logic          wvalid;
      logic          bready;
      logic [AW-1:0] araddr;
      logic          arvalid;
      logic          rready;
   } pde_axi_req_t;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic [1:0]  bresp;
      logic        bvalid;
      logic        arready;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic        rvalid;
   } pde_axi_rsp_t;
endpackage
`default_nettype wire

// >>> hw/pde_pin_drive.sv
// One pin's drive decoder: mode code, data and output enable to pad controls.
// Assumes the pad model resolves strong/resistive drive from these levels.
`default_nettype none
module pde_pin_drive (
   input  wire logic                        data_i,
   input  wire pde_pkg::pde_drive_mode_code_t mode_i,
   input  wire logic                        bidir_i,
   input  wire logic                        oe_i,
   input  wire logic                        slow_i,
   input  wire logic                        ibuf_dis_i,
   input  wire logic                        reg_lvl_i,
   output pde_pkg::pde_pad_t                pad_o
);
   pde_pkg::pde_drive_mode_code_t eff;

   always_comb begin
      eff = mode_i;
      // RL9 Bidir uses oe
      if (bidir_i && !oe_i) begin
         eff = pde_pkg::DM_DIG_INP;
      end
      // RL7 Pulls off when regulated
      if (reg_lvl_i && (eff == pde_pkg::DM_PULL_UP || eff == pde_pkg::DM_PULL_DN ||
                        eff == pde_pkg::DM_PULL_UD)) begin
         eff = pde_pkg::DM_DIG_INP;
      end
      pad_o = '0;
      pad_o.reg_lvl = reg_lvl_i;
      // RL18 Code to drive
      unique case (eff)
         // RL1 Analog off
         pde_pkg::DM_ANA_OFF: pad_o.in_en = 1'b0;
         // RL2 Digital input
         pde_pkg::DM_DIG_INP: pad_o.in_en = 1'b1;
         // RL3 Resistive pulls
         pde_pkg::DM_PULL_UP: begin
            pad_o.res_hi    = data_i;
            pad_o.strong_lo = !data_i;
            pad_o.in_en     = 1'b1;
         end
         pde_pkg::DM_PULL_DN: begin
            pad_o.strong_hi = data_i;
            pad_o.res_lo    = !data_i;
            pad_o.in_en     = 1'b1;
         end
         // RL4 Open drain
         pde_pkg::DM_OD_LOW: begin
            pad_o.strong_lo = !data_i;
            pad_o.in_en     = 1'b1;
         end
         pde_pkg::DM_OD_HIGH: begin
            pad_o.strong_hi = data_i;
            pad_o.in_en     = 1'b1;
         end
         // RL5 Strong drive
         pde_pkg::DM_STRONG: begin
            pad_o.strong_hi = data_i;
            pad_o.strong_lo = !data_i;
            pad_o.in_en     = 1'b1;
         end
         // RL6 Combined pulls
         pde_pkg::DM_PULL_UD: begin
            pad_o.res_hi = data_i;
            pad_o.res_lo = !data_i;
            pad_o.in_en  = 1'b1;
         end
      endcase
      // RL10 Slew in strong/od
      pad_o.slow = slow_i && (eff == pde_pkg::DM_STRONG || eff == pde_pkg::DM_OD_LOW ||
                              eff == pde_pkg::DM_OD_HIGH);
      // RL14 Buffer disable
      if (ibuf_dis_i) begin
         pad_o.in_en = 1'b0;
      end
   end
endmodule
`default_nettype wire

// >>> hw/pde_port.sv
// Eight-pin I/O port: drive modes, slew, bidir, input buffers, edge status, special pins.
// Assumes AXI4-Lite master on clock_i; pin inputs and aux enables are asynchronous.
//
// Design decisions made here: the placing of the registers and the AXI4-Lite slave port.
`default_nettype none

// Overview of operation
// RL1: After reset every pin is analog high impedance, no drive, no input.
// RL2: Digital high impedance: driver off, input buffer on.
// RL3: Single pull modes: strong one way, resistor the other, in and out.
// RL4: Open drain modes: strong one way, high impedance the other.
// RL5: Strong mode drives both levels; meant for outputs.
// RL6: Combined pull mode: resistor up for one, resistor down for zero.
// RL7: Regulated-level special pins lose all resistive pull modes.
// RL8: Settings reachable by port form and per-pin form, interchangeably.
// RL9: Bidirectional pins switch to digital input when selected aux enable low.
// RL10: Per pin slow slew, effective only in strong and open drain.
// RL11: Each pin detects rise, fall, both or none; one port interrupt.
// RL12: Edge sets status bit and raises port interrupt request.
// RL13: Edge detection runs always, no level detection. Here edges are seen only while the pin's input buffer is on.
// RL14: Port LVTTL threshold select; per pin input buffer disable.
// RL15: Special pin chooses bank supply or regulated output high level.
// RL16: Pin pairs share threshold: half or 0.4 bank, half or full reference.
// RL17: Pin pair comparator mode with optional per pin hysteresis.
// RL18: Three-bit drive code maps zero to seven in listed order.
// RL19: Pin reads come from pin state, writes go to output value.
// RL20: Drive state and output value hold until changed or reset.
// RL21: Reading status clears read bits; request high while any set.
module pde_port (
   input  wire logic                 clock_i,
   input  wire logic                 resetn_i,
   input  wire pde_pkg::pde_axi_req_t axi_i,
   output pde_pkg::pde_axi_rsp_t     axi_o,
   input  wire logic [7:0]           pin_in_i,
   input  wire logic [15:0]          aux_oe_i,
   output pde_pkg::pde_pad_t [7:0]   pad_o,
   output logic                      lvttl_o,
   output logic [7:0]                hyst_o,
   output logic [7:0]                ref_sel_o,
   output logic [3:0]                cmp_mode_o,
   output logic                      irq_o
);
   typedef struct packed {
      logic [7:0]  outv;
      logic [7:0]  dm0;
      logic [7:0]  dm1;
      logic [7:0]  dm2;
      logic [7:0]  slw;
      logic [7:0]  ibd;
      logic [7:0]  bie;
      logic [7:0]  it0;
      logic [7:0]  it1;
      logic [7:0]  ist;
      logic        lvttl;
      logic [27:0] spc;
      logic [63:0] auxs;
      logic [7:0]  s1;
      logic [7:0]  s2;
      logic [7:0]  prev;
      logic [15:0] oe1;
      logic [15:0] oe2;
      logic [7:0]  aw;
      logic        awv;
      logic [31:0] wd;
      logic [3:0]  ws;
      logic        wv;
      logic        bv;
      logic [1:0]  br;
      logic        rv;
      logic [31:0] rd;
      logic [1:0]  rr;
      logic        awrdy;
      logic        wrdy;
      logic        arrdy;
      logic        irq;
      pde_pkg::pde_pad_t [7:0] pad;
   } pde_st_t;

   pde_st_t s_r, s_nxt;
   pde_pkg::pde_pad_t [7:0] pad_w;
   logic [7:0] oe_sel;
   logic [7:0] in_val;

   generate
      for (genvar g = 0; g < 8; g++) begin : g_pin
         // RL9 Pick aux enable
         assign oe_sel[g] = s_r.oe2[s_r.auxs[g*4 +: 4]];
         pde_pin_drive u_drv (
            .data_i     (s_r.outv[g]),
            .mode_i     (pde_pkg::pde_drive_mode_code_t'({s_r.dm2[g], s_r.dm1[g], s_r.dm0[g]})),
            .bidir_i    (s_r.bie[g]),
            .oe_i       (oe_sel[g]),
            .slow_i     (s_r.slw[g]),
            .ibuf_dis_i (s_r.ibd[g]),
            .reg_lvl_i  (s_r.spc[pde_pkg::SC_REG + g]),
            .pad_o      (pad_w[g])
         );
         // RL1 No input when buffer off
         assign in_val[g] = s_r.s2[g] & s_r.pad[g].in_en;
      end
   endgenerate

   function automatic logic [31:0] pin_word(input pde_st_t s, input int p);
      logic [31:0] w;
      w = '0;
      w[pde_pkg::PF_OUT]      = s.outv[p];
      w[pde_pkg::PF_PV]       = s.s2[p] & s.pad[p].in_en;
      w[pde_pkg::PF_DM +: 3]  = {s.dm2[p], s.dm1[p], s.dm0[p]};
      w[pde_pkg::PF_SLW]      = s.slw[p];
      w[pde_pkg::PF_BIE]      = s.bie[p];
      w[pde_pkg::PF_IBD]      = s.ibd[p];
      return w;
   endfunction

   always_comb begin
      logic        rd;
      logic [7:0]  wb;
      logic [2:0]  pi;
      logic [7:0]  ev;
      logic [31:0] rw;
      logic        ok;
      s_nxt = s_r;
      rd = 1'b0;
      wb = '0;
      pi = '0;
      ev = '0;
      rw = '0;
      ok = 1'b1;
      s_nxt.s1   = pin_in_i;
      s_nxt.s2   = s_r.s1;
      s_nxt.oe1  = aux_oe_i;
      s_nxt.oe2  = s_r.oe1;
      s_nxt.prev = in_val;
      s_nxt.pad  = pad_w;
      // Write address/data capture
      if (axi_i.awvalid && !s_r.awv && !s_r.bv) begin
         s_nxt.awv = 1'b1;
         s_nxt.aw  = axi_i.awaddr;
      end
      if (axi_i.wvalid && !s_r.wv && !s_r.bv) begin
         s_nxt.wv = 1'b1;
         s_nxt.wd = axi_i.wdata;
         s_nxt.ws = axi_i.wstrb;
      end
      if (s_r.bv && axi_i.bready) begin
         s_nxt.bv = 1'b0;
      end
      if (s_r.rv && axi_i.rready) begin
         s_nxt.rv = 1'b0;
      end
      // RL11 Edge detect per type
      for (int i = 0; i < 8; i++) begin
         unique case (pde_pkg::pde_edge_t'({s_r.it1[i], s_r.it0[i]}))
            pde_pkg::IT_NONE: ev[i] = 1'b0;
            pde_pkg::IT_RISE: ev[i] = in_val[i] & ~s_r.prev[i];
            pde_pkg::IT_FALL: ev[i] = ~in_val[i] & s_r.prev[i];
            pde_pkg::IT_BOTH: ev[i] = in_val[i] ^ s_r.prev[i];
         endcase
      end
      // Register write
      if (s_r.awv && s_r.wv) begin
         wb = s_r.wd[7:0];
         s_nxt.awv = 1'b0;
         s_nxt.wv  = 1'b0;
         s_nxt.bv  = 1'b1;
         s_nxt.br  = pde_pkg::RESP_OK;
         // RL19 Writes hit output value
         // RL8 Port form writes
         if (s_r.ws[0]) begin
            unique case (s_r.aw)
               pde_pkg::A_OUT:   s_nxt.outv  = wb;
               pde_pkg::A_PV:    ;
               pde_pkg::A_DM0:   s_nxt.dm0   = wb;
               pde_pkg::A_DM1:   s_nxt.dm1   = wb;
               pde_pkg::A_DM2:   s_nxt.dm2   = wb;
               pde_pkg::A_SLW:   s_nxt.slw   = wb;
               pde_pkg::A_IBD:   s_nxt.ibd   = wb;
               pde_pkg::A_BIE:   s_nxt.bie   = wb;
               pde_pkg::A_IT0:   s_nxt.it0   = wb;
               pde_pkg::A_IT1:   s_nxt.it1   = wb;
               pde_pkg::A_IST:   ;
               // RL14 Threshold select
               pde_pkg::A_CFG:   s_nxt.lvttl = wb[pde_pkg::CF_LVTTL];
               pde_pkg::A_SPC:   ;
               pde_pkg::A_AUXS:  ;
               pde_pkg::A_AUXS1: ;
               default:          ok = 1'b0;
            endcase
         end
         // RL15 Special pin config
         if (s_r.aw == pde_pkg::A_SPC) begin
            for (int b = 0; b < 4; b++) begin
               if (s_r.ws[b]) begin
                  for (int k = 0; k < 8; k++) begin
                     if (b*8 + k < 28) begin
                        s_nxt.spc[b*8 + k] = s_r.wd[b*8 + k];
                     end
                  end
               end
            end
         end
         if (s_r.aw == pde_pkg::A_AUXS || s_r.aw == pde_pkg::A_AUXS1) begin
            for (int b = 0; b < 4; b++) begin
               if (s_r.ws[b]) begin
                  s_nxt.auxs[(s_r.aw == pde_pkg::A_AUXS1 ? 32 : 0) + b*8 +: 8] =
                     s_r.wd[b*8 +: 8];
               end
            end
         end
         // RL8 Per-pin form writes
         if (s_r.aw >= pde_pkg::A_PIN0 && s_r.aw <= pde_pkg::A_PIN7 && s_r.aw[1:0] == 2'b00) begin
            ok = 1'b1;
            pi = 3'((s_r.aw - pde_pkg::A_PIN0) >> 2);
            if (s_r.ws[0]) begin
               s_nxt.outv[pi] = wb[pde_pkg::PF_OUT];
               s_nxt.dm0[pi]  = wb[pde_pkg::PF_DM];
               s_nxt.dm1[pi]  = wb[pde_pkg::PF_DM + 1];
               s_nxt.dm2[pi]  = wb[pde_pkg::PF_DM + 2];
               s_nxt.slw[pi]  = wb[pde_pkg::PF_SLW];
               s_nxt.bie[pi]  = wb[pde_pkg::PF_BIE];
               s_nxt.ibd[pi]  = wb[pde_pkg::PF_IBD];
            end
         end
         if (!ok) begin
            s_nxt.br = pde_pkg::RESP_ERR;
         end
      end
      // Register read
      if (axi_i.arvalid && !s_r.rv) begin
         rd = 1'b1;
         s_nxt.rv = 1'b1;
         s_nxt.rr = pde_pkg::RESP_OK;
         unique case (axi_i.araddr)
            pde_pkg::A_OUT:   rw = {24'h000000, s_r.outv};
            // RL19 Reads from pin state
            pde_pkg::A_PV:    rw = {24'h000000, in_val};
            pde_pkg::A_DM0:   rw = {24'h000000, s_r.dm0};
            pde_pkg::A_DM1:   rw = {24'h000000, s_r.dm1};
            pde_pkg::A_DM2:   rw = {24'h000000, s_r.dm2};
            pde_pkg::A_SLW:   rw = {24'h000000, s_r.slw};
            pde_pkg::A_IBD:   rw = {24'h000000, s_r.ibd};
            pde_pkg::A_BIE:   rw = {24'h000000, s_r.bie};
            pde_pkg::A_IT0:   rw = {24'h000000, s_r.it0};
            pde_pkg::A_IT1:   rw = {24'h000000, s_r.it1};
            pde_pkg::A_IST:   rw = {24'h000000, s_r.ist};
            pde_pkg::A_CFG:   rw = {31'h00000000, s_r.lvttl};
            pde_pkg::A_SPC:   rw = {4'h0, s_r.spc};
            pde_pkg::A_AUXS:  rw = s_r.auxs[31:0];
            pde_pkg::A_AUXS1: rw = s_r.auxs[63:32];
            default: begin
               if (axi_i.araddr >= pde_pkg::A_PIN0 && axi_i.araddr <= pde_pkg::A_PIN7 &&
                   axi_i.araddr[1:0] == 2'b00) begin
                  rw = pin_word(s_r, int'((axi_i.araddr - pde_pkg::A_PIN0) >> 2));
               end else begin
                  s_nxt.rr = pde_pkg::RESP_ERR;
               end
            end
         endcase
         s_nxt.rd = rw;
      end
      // RL21 Clear on read, set wins
      if (rd && axi_i.araddr == pde_pkg::A_IST) begin
         s_nxt.ist = s_r.ist & ~s_r.ist;
      end
      // RL12 Edge sets status
      // RL13 Always running
      s_nxt.ist = s_nxt.ist | ev;
      s_nxt.irq = |s_nxt.ist;
      s_nxt.awrdy = !s_nxt.awv && !s_nxt.bv;
      s_nxt.wrdy  = !s_nxt.wv && !s_nxt.bv;
      s_nxt.arrdy = !s_nxt.rv;
   end

   // RL20 State held until changed
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign axi_o.awready = s_r.awrdy;
   assign axi_o.wready  = s_r.wrdy;
   assign axi_o.bvalid  = s_r.bv;
   assign axi_o.bresp   = s_r.br;
   assign axi_o.arready = s_r.arrdy;
   assign axi_o.rvalid  = s_r.rv;
   assign axi_o.rdata   = s_r.rd;
   assign axi_o.rresp   = s_r.rr;
   assign pad_o         = s_r.pad;
   assign lvttl_o       = s_r.lvttl;
   // RL17 Hysteresis and comparator
   assign hyst_o        = s_r.spc[pde_pkg::SC_HYST +: 8];
   assign cmp_mode_o    = s_r.spc[pde_pkg::SC_CMP +: 4];
   // RL16 Pair threshold select
   assign ref_sel_o     = s_r.spc[pde_pkg::SC_REF +: 8];
   // RL12 Request while any set
   assign irq_o         = s_r.irq;
endmodule
`default_nettype wire

// >>> dv/pde_port_sva.sv
// Checker for the eight-pin port: pad decode, bus answers, edge status.
// Assumes it is bound to pde_port and sees only that module's ports.
`default_nettype none
module pde_port_chk (
   input wire logic                    clock_i,
   input wire logic                    resetn_i,
   input wire pde_pkg::pde_axi_req_t   axi_i,
   input wire pde_pkg::pde_axi_rsp_t   axi_o,
   input wire logic [7:0]              pin_in_i,
   input wire pde_pkg::pde_pad_t [7:0] pad_o,
   input wire logic                    lvttl_o,
   input wire logic                    irq_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic        clash, slowres, regres;
   logic [3:0]  quiet_r;
   logic [7:0]  pin_r, aw_r;
   logic [31:0] w_r;
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!resetn_i);
   // Per pin: more than one driver, slow or regulated level on a resistor
   always_comb begin
      clash = 1'b0;
      slowres = 1'b0;
      regres = 1'b0;
      for (int g = 0; g < 8; g++) begin
         clash |= ($countones({pad_o[g].strong_hi, pad_o[g].strong_lo,
                               pad_o[g].res_hi, pad_o[g].res_lo}) > 1);
         slowres |= pad_o[g].slow & (pad_o[g].res_hi | pad_o[g].res_lo);
         regres |= pad_o[g].reg_lvl & (pad_o[g].res_hi | pad_o[g].res_lo);
      end
   end
   // Cycles since the pins last moved, and last write seen
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         quiet_r <= 4'h0;
         pin_r <= 8'h00;
         aw_r <= 8'h00;
         w_r <= 32'h0;
      end else begin
         pin_r <= pin_in_i;
         if (pin_in_i != pin_r) quiet_r <= 4'h0;
         else if (quiet_r != 4'hf) quiet_r <= quiet_r + 4'h1;
         if (axi_i.awvalid && axi_o.awready) aw_r <= axi_i.awaddr;
         if (axi_i.wvalid && axi_o.wready) w_r <= axi_i.wdata;
      end
   end
   sequence ist_read;
      axi_i.arvalid && axi_o.arready && axi_i.araddr == pde_pkg::A_IST ##1 axi_o.rvalid;
   endsequence
   chk_reset_pads: assert property ($rose(resetn_i) |-> pad_o == '0 && !irq_o)
      else $error("pads not idle after reset");
   chk_drive_single: assert property (!clash)
      else $error("pin has two drivers");
   chk_slow_res: assert property (!slowres)
      else $error("slow slew on resistive drive");
   chk_reg_nopull: assert property (!regres)
      else $error("regulated pin on resistor");
   chk_read_next: assert property (axi_i.arvalid && axi_o.arready |=> axi_o.rvalid)
      else $error("read answer late");
   chk_irq_cause: assert property ($rose(irq_o) |-> quiet_r < 4'h8)
      else $error("irq without pin edge");
   chk_irq_clear: assert property (ist_read ##0 quiet_r > 4'ha |-> ##[1:3] !irq_o)
      else $error("irq stays after status read");
   chk_cfg_lvttl: assert property ($rose(axi_o.bvalid) && aw_r == pde_pkg::A_CFG
      |-> ##[0:2] lvttl_o == w_r[0])
      else $error("threshold select not applied");
endmodule
bind pde_port pde_port_chk u_chk (
   .clock_i(clock_i), .resetn_i(resetn_i), .axi_i(axi_i), .axi_o(axi_o),
   .pin_in_i(pin_in_i), .pad_o(pad_o), .lvttl_o(lvttl_o), .irq_o(irq_o));
`default_nettype wire

// >>> dv/pde_pin_ext.sv
// Outside circuits on the port pins: resolve pad drive against an outside driver.
// Assumes strong drive beats the outside driver, which beats resistors.
`default_nettype none
module pde_pin_ext (
   input  wire logic                   clock_i,
   input  wire pde_pkg::pde_pad_t [7:0] pad_i,
   input  wire logic [7:0]             ext_en_i,
   input  wire logic [7:0]             ext_val_i,
   output logic [7:0]                  pin_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] last_r = 8'h00;
   logic [7:0] held;
   // outside driver takes a pin the pad releases
   always_comb begin
      for (int g = 0; g < 8; g++) begin
         held[g] = 1'b1;
         if (pad_i[g].strong_hi | pad_i[g].strong_lo) pin_o[g] = pad_i[g].strong_hi;
         else if (ext_en_i[g]) pin_o[g] = ext_val_i[g];
         else if (pad_i[g].res_hi | pad_i[g].res_lo) pin_o[g] = pad_i[g].res_hi;
         else begin
            // Floating pin shows the inverse of its last driven level
            pin_o[g] = ~last_r[g];
            held[g] = 1'b0;
         end
      end
   end
   always_ff @(posedge clock_i) begin
      last_r <= (pin_o & held) | (last_r & ~held);
   end
endmodule
`default_nettype wire

// >>> dv/testbench.sv
// Testbench for the eight-pin port: bus access, pad decode, edges, special pins.
// Assumes pde_port with its bound checker and the outside-circuit model.
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic                    clock_i = 1'b0;
   logic                    resetn_i = 1'b0;
   pde_pkg::pde_axi_req_t   req = '0;
   pde_pkg::pde_axi_rsp_t   rsp;
   pde_pkg::pde_pad_t [7:0] pad;
   logic [7:0]              pin, hyst, refs;
   logic [7:0]              ext_en = 8'h00;
   logic [7:0]              ext_val = 8'h00;
   logic [15:0]             aux_oe = 16'h0000;
   logic [3:0]              cmp;
   logic                    lvttl, irq;
   logic [31:0]             rdat;
   logic [1:0]              resp;
   int                      failures = 0;
   int                      checked = 0;
   pde_port dut (.clock_i(clock_i), .resetn_i(resetn_i), .axi_i(req), .axi_o(rsp),
      .pin_in_i(pin), .aux_oe_i(aux_oe), .pad_o(pad), .lvttl_o(lvttl), .hyst_o(hyst),
      .ref_sel_o(refs), .cmp_mode_o(cmp), .irq_o(irq));
   pde_pin_ext ext (.clock_i(clock_i), .pad_i(pad), .ext_en_i(ext_en),
      .ext_val_i(ext_val), .pin_o(pin));
   initial begin
      forever #4 clock_i = ~clock_i;
   end
   task automatic close_out;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clock_i);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock_i);
      req.awaddr <= a;
      req.awvalid <= 1'b1;
      req.wdata <= d;
      req.wstrb <= 4'hf;
      req.wvalid <= 1'b1;
      req.bready <= 1'b1;
      forever begin
         @(posedge clock_i);
         if (rsp.awready) req.awvalid <= 1'b0;
         if (rsp.wready) req.wvalid <= 1'b0;
         if (rsp.bvalid) begin
            resp = rsp.bresp;
            req.bready <= 1'b0;
            break;
         end
      end
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clock_i);
      req.araddr <= a;
      req.arvalid <= 1'b1;
      req.rready <= 1'b1;
      forever begin
         @(posedge clock_i);
         if (rsp.arready) req.arvalid <= 1'b0;
         if (rsp.rvalid) begin
            rdat = rsp.rdata;
            resp = rsp.rresp;
            req.rready <= 1'b0;
            break;
         end
      end
   endtask
   task automatic mode(input logic [2:0] c);
      wr(pde_pkg::A_DM0, {24'h0, {8{c[0]}}});
      wr(pde_pkg::A_DM1, {24'h0, {8{c[1]}}});
      wr(pde_pkg::A_DM2, {24'h0, {8{c[2]}}});
   endtask
   // Expected pad for a drive code, data and slow slew bit
   function automatic pde_pkg::pde_pad_t xp(input logic [2:0] c, input logic d, s);
      xp = '0;
      xp.in_en = (c != 3'h0);
      xp.slow = s & (c >= 3'h4) & (c != 3'h7);
      case (c)
         3'h2: {xp.res_hi, xp.strong_lo} = {d, !d};
         3'h3: {xp.strong_hi, xp.res_lo} = {d, !d};
         3'h4: xp.strong_lo = !d;
         3'h5: xp.strong_hi = d;
         3'h6: {xp.strong_hi, xp.strong_lo} = {d, !d};
         3'h7: {xp.res_hi, xp.res_lo} = {d, !d};
         default: ;
      endcase
   endfunction
   task automatic t_modes;
      wr(pde_pkg::A_SLW, 32'hff);
      for (int k = 0; k < 16; k++) begin
         mode(k[3:1]);
         wr(pde_pkg::A_OUT, {24'h0, {8{k[0]}}});
         cyc(3);
         chk("pad0", pad[0], xp(k[3:1], k[0], 1'b1));
         chk("pad7", pad[7], xp(k[3:1], k[0], 1'b1));
         rd(pde_pkg::A_PIN0 + 8'h0c);
         chk("pin3 word", rdat & 32'hfd, {24'h0, 3'b001, k[3:1], 1'b0, k[0]});
      end
   endtask
   task automatic t_pinform;
      logic [7:0] ad [7];
      logic [6:0] ex;
      ad = '{pde_pkg::A_OUT, pde_pkg::A_DM0, pde_pkg::A_DM1, pde_pkg::A_DM2,
             pde_pkg::A_SLW, pde_pkg::A_IBD, pde_pkg::A_BIE};
      ex = 7'b1101110;
      wr(pde_pkg::A_PIN0 + 8'h14, 32'hb5);
      for (int i = 0; i < 7; i++) begin
         rd(ad[i]);
         chk("port bit5", {31'h0, rdat[5]}, {31'h0, ex[6-i]});
      end
      chk("pad5", pad[5], xp(3'h5, 1'b1, 1'b1) & 7'h7b);
   endtask
   task automatic t_inputs;
      mode(3'h1);
      wr(pde_pkg::A_IBD, 32'h0f);
      wr(pde_pkg::A_OUT, 32'h5a);
      ext_en <= 8'hff;
      ext_val <= 8'ha5;
      cyc(4);
      rd(pde_pkg::A_PV);
      chk("pin state", rdat, 32'ha0);
      rd(pde_pkg::A_OUT);
      chk("out value", rdat, 32'h5a);
      wr(pde_pkg::A_CFG, 32'h1);
      cyc(2);
      chk("lvttl", lvttl, 1'b1);
      wr(pde_pkg::A_IBD, 32'h0);
      rd(8'h60);
      chk("unmapped read", resp, pde_pkg::RESP_ERR);
      wr(8'h3c, 32'h1);
      chk("unmapped write", resp, pde_pkg::RESP_ERR);
   endtask
   task automatic t_edges;
      logic e;
      ext_val <= 8'h00;
      for (int t = 0; t < 4; t++) begin
         wr(pde_pkg::A_IT0, {29'h0, t[0], 2'h0});
         wr(pde_pkg::A_IT1, {29'h0, t[1], 2'h0});
         rd(pde_pkg::A_IST);
         for (int v = 1; v >= 0; v--) begin
            e = v ? t[0] : t[1];
            ext_val <= {5'h0, v[0], 2'h0};
            cyc(12);
            chk("irq", irq, e);
            rd(pde_pkg::A_IST);
            chk("status", rdat, {29'h0, e, 2'h0});
            cyc(3);
            chk("irq cleared", irq, 1'b0);
         end
      end
   endtask
   task automatic t_bidir;
      ext_en <= 8'h00;
      mode(3'h6);
      wr(pde_pkg::A_OUT, 32'hff);
      wr(pde_pkg::A_BIE, 32'h01);
      wr(pde_pkg::A_AUXS, 32'h5);
      for (int v = 0; v < 2; v++) begin
         aux_oe <= v ? 16'h0020 : 16'hffdf;
         cyc(6);
         chk("bidir pin0", pad[0], v ? xp(3'h6, 1'b1, 1'b1) : xp(3'h1, 1'b1, 1'b1));
         chk("plain pin1", pad[1], xp(3'h6, 1'b1, 1'b1));
      end
   endtask
   task automatic t_spc;
      wr(pde_pkg::A_SPC, 32'h096ae401);
      mode(3'h2);
      cyc(3);
      chk("hyst", hyst, 8'h96);
      chk("cmp", cmp, 4'ha);
      chk("ref", refs, 8'he4);
      chk("reg pin0", pad[0], xp(3'h1, 1'b1, 1'b1) | 7'h01);
      chk("std pin1", pad[1], xp(3'h2, 1'b1, 1'b1));
   endtask
   initial begin
      repeat (4) @(posedge clock_i);
      resetn_i <= 1'b1;
      @(posedge clock_i);
      chk("pads idle", {31'h0, |pad}, 32'h0);
      chk("irq idle", irq, 1'b0);
      t_modes();
      t_pinform();
      t_inputs();
      t_edges();
      t_bidir();
      t_spc();
      close_out();
   end
   initial begin
      repeat (20000) @(posedge clock_i);
      failures++;
      close_out();
   end
endmodule
`default_nettype wire
